// ### include/ulfc_pkg.sv
// Types and shared parity and word length helpers for the line format block.
// Assumes the register header is compiled alongside.
package ulfc_pkg;
	typedef struct packed {
		logic dlab;
		logic brk;
		logic force_par;
		logic even;
		logic pen;
		logic stop2;
		logic [1:0] wlen;
	} ulfc_lfc_t;

	typedef enum logic [2:0] {st_idle, st_start, st_data, st_par, st_stop} ulfc_ser_t;
	typedef enum logic [2:0] {sel_none, sel_data, sel_divl, sel_stat, sel_divh, sel_efr, sel_lfc} ulfc_sel_t;

	typedef struct packed {
		logic read;
		logic write;
		logic [2:0] address;
		logic [31:0] writedata;
	} ulfc_av_req_t;

	typedef struct packed {
		logic waitrequest;
		logic [31:0] readdata;
	} ulfc_av_rsp_t;

	typedef struct packed {
		ulfc_ser_t st;
		logic [16:0] cnt;
		logic [7:0] sh;
		logic [3:0] nbit;
		logic par;
		logic busy;
		logic txd;
	} ulfc_tx_state_t;

	typedef struct packed {
		ulfc_lfc_t lfc;
		logic [15:0] div;
		logic [7:0] efr;
		logic [7:0] thr;
		logic thr_full;
		logic [7:0] rbr;
		logic rdy;
		logic perr;
		logic ferr;
		logic ovr;
		ulfc_ser_t rst;
		logic [16:0] rcnt;
		logic [7:0] rsh;
		logic [3:0] rbit;
		logic rpe;
		logic s1;
		logic s2;
		ulfc_av_rsp_t rsp;
	} ulfc_top_state_t;

	function automatic logic [3:0] ulfc_nbits(input logic [1:0] wlen);
		return 4'h5 + {2'h0, wlen};
	endfunction : ulfc_nbits

	function automatic logic ulfc_parity(input logic [7:0] d, input ulfc_lfc_t c);
		logic [7:0] m;
		m = 8'hFF >> (4'h8 - ulfc_nbits(c.wlen));
		if (c.force_par) return ~c.even;
		return (^(d & m)) ^ ~c.even;
	endfunction : ulfc_parity
endpackage : ulfc_pkg

// ### include/ulfc_regs.svh
// Register offsets, field positions, reset values and timing for the line format block.
// Assumes a 20 MHz core clock and word-addressed Avalon-MM register access.
`ifndef ULFC_REGS_SVH
`define ULFC_REGS_SVH

// Word indices; byte address is four times the index
`define ULFC_IDX_DATA 3'h0
`define ULFC_IDX_STAT 3'h1
`define ULFC_IDX_EFR 3'h2
`define ULFC_IDX_LFC 3'h3

// Status field positions
`define ULFC_ST_RDY 0
`define ULFC_ST_PERR 1
`define ULFC_ST_FERR 2
`define ULFC_ST_OVR 3
`define ULFC_ST_THRE 4
`define ULFC_ST_TIDLE 5

// Reset values
`define ULFC_LFC_RST 8'h00
`define ULFC_EFR_RST 8'h00
`define ULFC_CLK_HZ 20000000
`define ULFC_BAUD_DEF 9600
`define ULFC_DIV_RST 16'(`ULFC_CLK_HZ / `ULFC_BAUD_DEF)

`endif

// ### rtl/ulfc_top.sv
// Line format control, registers, receiver and transmit holding for one serial channel.
// Assumes an Avalon-MM master on clk and an asynchronous serial line on rxd.
//
// The address map and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
`include "ulfc_regs.svh"
module ulfc_top (
	input wire logic clk, // Core clock, 20 MHz
	input wire logic reset_n, // Async reset, active low
	input ulfc_pkg::ulfc_av_req_t av_req, // Avalon request
	output ulfc_pkg::ulfc_av_rsp_t av_rsp, // Avalon answer
	input wire logic rxd, // Serial input
	output logic txd // Serial output
);
	import ulfc_pkg::*;

	localparam ulfc_top_state_t TOP_RST = '{
		`ULFC_LFC_RST, `ULFC_DIV_RST, `ULFC_EFR_RST, 8'h00, 1'b0, 8'h00,
		1'b0, 1'b0, 1'b0, 1'b0, st_idle, 17'h00000, 8'h00, 4'h0, 1'b0,
		1'b1, 1'b1, '{1'b1, 32'h00000000}};

	ulfc_top_state_t s;
	ulfc_top_state_t n;
	ulfc_sel_t sel;
	logic commit;
	logic tx_load;
	logic tx_busy;
	logic rx;
	logic rtick;
	logic [16:0] bit_len;
	logic [3:0] nb;
	logic [7:0] aligned;
	logic [7:0] stat;
	logic [7:0] rd8;

	function automatic ulfc_sel_t ulfc_dec(input logic [2:0] a, input logic dlab);
		if (a == `ULFC_IDX_DATA) begin
			return dlab ? sel_divl : sel_data;
		end else if (a == `ULFC_IDX_STAT) begin
			return dlab ? sel_divh : sel_stat;
		end else if (a == `ULFC_IDX_EFR && dlab) begin
			return sel_efr;
		end else if (a == `ULFC_IDX_LFC) begin
			return sel_lfc;
		end else begin
			return sel_none;
		end
	endfunction : ulfc_dec

	ulfc_tx u_tx (
		.clk(clk),
		.reset_n(reset_n),
		.cfg(s.lfc),
		.divisor(s.div),
		.load(tx_load),
		.data(s.thr),
		.busy(tx_busy),
		.txd(txd)
	);

	always_comb begin
		n = s;
		rx = s.s2;
		n.s1 = rxd;
		n.s2 = s.s1;
		bit_len = (s.div == 16'h0000) ? 17'h00001 : {1'b0, s.div};
		nb = ulfc_nbits(s.lfc.wlen);
		aligned = s.rsh >> (4'h8 - nb);
		stat = 8'h00;
		stat[`ULFC_ST_RDY] = s.rdy;
		stat[`ULFC_ST_PERR] = s.perr;
		stat[`ULFC_ST_FERR] = s.ferr;
		stat[`ULFC_ST_OVR] = s.ovr;
		stat[`ULFC_ST_THRE] = ~s.thr_full;
		stat[`ULFC_ST_TIDLE] = ~s.thr_full & ~tx_busy;
		sel = ulfc_dec(av_req.address, s.lfc.dlab);
		case (sel)
			sel_data: rd8 = s.rbr;
			sel_divl: rd8 = s.div[7:0];
			sel_divh: rd8 = s.div[15:8];
			sel_stat: rd8 = stat;
			sel_efr: rd8 = s.efr;
			sel_lfc: rd8 = s.lfc;
			default: rd8 = 8'h00;
		endcase

		// Transmit holding hands over to the shifter
		tx_load = s.thr_full & ~tx_busy;
		if (tx_load) n.thr_full = 1'b0;

		// Bus: answer one cycle after the request, commit while waitrequest is low
		commit = ~s.rsp.waitrequest & (av_req.read | av_req.write);
		n.rsp.waitrequest = 1'b1;
		if (s.rsp.waitrequest && (av_req.read || av_req.write)) begin
			n.rsp.waitrequest = 1'b0;
			if (av_req.read) n.rsp.readdata = {24'h000000, rd8};
		end
		if (commit && av_req.write) begin
			case (sel)
				sel_data: begin
					n.thr = av_req.writedata[7:0];
					n.thr_full = 1'b1;
				end
				sel_divl: n.div[7:0] = av_req.writedata[7:0];
				sel_divh: n.div[15:8] = av_req.writedata[7:0];
				sel_efr: n.efr = av_req.writedata[7:0];
				sel_lfc: n.lfc = av_req.writedata[7:0];
				default: ;
			endcase
		end
		if (commit && av_req.read) begin
			if (sel == sel_data) n.rdy = 1'b0;
			if (sel == sel_stat) begin
				n.perr = 1'b0;
				n.ferr = 1'b0;
				n.ovr = 1'b0;
			end
		end

		////////////////////////////////////////////////////////////////////////////////
		// Receiver; its flag sets come after the bus clears so that a set wins
		rtick = (s.rcnt == bit_len - 17'h00001);
		n.rcnt = rtick ? 17'h00000 : s.rcnt + 17'h00001;
		case (s.rst)
			st_idle: begin
				n.rcnt = 17'h00000;
				if (!rx) n.rst = st_start;
			end
			st_start: if (s.rcnt == (bit_len >> 1)) begin
				n.rcnt = 17'h00000;
				n.rbit = 4'h0;
				n.rpe = 1'b0;
				n.rst = rx ? st_idle : st_data;
			end
			st_data: if (rtick) begin
				n.rsh = {rx, s.rsh[7:1]};
				n.rbit = s.rbit + 4'h1;
				if (s.rbit == nb - 4'h1) n.rst = s.lfc.pen ? st_par : st_stop;
			end
			st_par: if (rtick) begin
				n.rpe = (rx != ulfc_parity(aligned, s.lfc));
				n.rst = st_stop;
			end
			st_stop: if (rtick) begin
				n.rst = st_idle;
				n.rbr = aligned;
				n.ovr = n.ovr | n.rdy;
				n.rdy = 1'b1;
				if (!rx) n.ferr = 1'b1;
				if (s.rpe) n.perr = 1'b1;
			end
			default: n.rst = st_idle;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s <= TOP_RST;
		end else begin
			s <= n;
		end
	end

	assign av_rsp = s.rsp;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	logic first;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			first <= 1'b1;
		end else begin
			first <= 1'b0;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	reset_zero_a: assert property (first |-> s.lfc == 8'h00)
		else $error("line format not zero after reset");
	div_closed_a: assert property (commit && av_req.write && !s.lfc.dlab
			|=> s.div == $past(s.div) && s.efr == $past(s.efr))
		else $error("divisor changed with access closed");
	div_read_a: assert property (s.rsp.waitrequest && av_req.read && s.lfc.dlab
			&& av_req.address == 3'h0 |=> s.rsp.readdata == {24'h000000, $past(s.div[7:0])})
		else $error("divisor not read with access open");
	parity_flag_a: assert property (s.rst == st_stop && n.rst == st_idle && s.rpe
			|=> s.perr ##1 (s.perr || !$past(commit)))
		else $error("parity error not flagged");
	forced_check_a: assert property (s.lfc.pen && s.lfc.force_par && s.rst == st_par
			&& n.rst == st_stop |=> s.rpe == $past(s.s2 == s.lfc.even))
		else $error("forced parity checked wrongly");

	////////////////////////////////////////////////////////////////////////////////
	// Bus handshake and line checks

	wait_answer_a: assert property (s.rsp.waitrequest && (av_req.read || av_req.write)
			|=> !s.rsp.waitrequest)
		else $error("request not answered in one cycle");

	wait_pulse_a: assert property (!s.rsp.waitrequest |=> s.rsp.waitrequest)
		else $error("waitrequest low for more than one cycle");

	upper_zero_a: assert property (s.rsp.readdata[31:8] == 24'h000000)
		else $error("read data upper bits not zero");

	efr_closed_a: assert property (s.rsp.waitrequest && av_req.read && !s.lfc.dlab
			&& av_req.address == `ULFC_IDX_EFR |=> s.rsp.readdata == 32'h00000000)
		else $error("enhanced register readable with access closed");

	break_pin_a: assert property (s.lfc.brk |=> !txd)
		else $error("break did not drive the pin low");

	rx_no_parity_a: assert property (s.rst == st_data && !s.lfc.pen && n.rst != st_data
			|-> n.rst == st_stop)
		else $error("receiver expected parity with parity disabled");

	ready_set_a: assert property (s.rst == st_stop && n.rst == st_idle |=> s.rdy)
		else $error("receive ready not set at stop bit");

	frame_err_a: assert property (s.rst == st_stop && n.rst == st_idle && !s.s2 |=> s.ferr)
		else $error("framing error not flagged");
endmodule : ulfc_top

// ### rtl/ulfc_tx.sv
// Serial transmitter shaped by the line format register.
// Assumes divisor is cycles per bit and load is a one-cycle pulse from the same clock.
`timescale 1ns/1ps
module ulfc_tx (
	input wire logic clk, // Core clock
	input wire logic reset_n, // Async reset, active low
	input ulfc_pkg::ulfc_lfc_t cfg, // Line format
	input wire logic [15:0] divisor, // Cycles per bit
	input wire logic load, // Start a character
	input wire logic [7:0] data, // Character to send
	output logic busy, // Character in progress
	output logic txd // Serial output
);
	import ulfc_pkg::*;

	localparam ulfc_tx_state_t TX_RST = '{st_idle, 17'h00000, 8'h00, 4'h0, 1'b0, 1'b0, 1'b1};

	ulfc_tx_state_t s;
	ulfc_tx_state_t n;
	logic [16:0] bit_len;
	logic [16:0] stop_len;
	logic [16:0] end_cnt;
	logic tick;
	logic lvl;

	always_comb begin
		bit_len = (divisor == 16'h0000) ? 17'h00001 : {1'b0, divisor};
		if (!cfg.stop2) begin
			stop_len = bit_len;
		end else if (cfg.wlen == 2'h0) begin
			stop_len = bit_len + (bit_len >> 1);
		end else begin
			stop_len = bit_len << 1;
		end
		end_cnt = ((s.st == st_stop) ? stop_len : bit_len) - 17'h00001;
		tick = (s.cnt == end_cnt);
		n = s;
		n.cnt = tick ? 17'h00000 : s.cnt + 17'h00001;
		case (s.st)
			st_idle: begin
				n.cnt = 17'h00000;
				if (load) begin
					n.st = st_start;
					n.sh = data;
					n.nbit = 4'h0;
					n.par = ulfc_parity(data, cfg);
					n.busy = 1'b1;
				end
			end
			st_start: if (tick) n.st = st_data;
			st_data: if (tick) begin
				n.sh = s.sh >> 1;
				n.nbit = s.nbit + 4'h1;
				if (s.nbit == ulfc_nbits(cfg.wlen) - 4'h1) begin
					n.st = cfg.pen ? st_par : st_stop;
				end
			end
			st_par: if (tick) n.st = st_stop;
			st_stop: if (tick) begin
				n.st = st_idle;
				n.busy = 1'b0;
			end
			default: n.st = st_idle;
		endcase
		case (n.st)
			st_start: lvl = 1'b0;
			st_data: lvl = n.sh[0];
			st_par: lvl = n.par;
			default: lvl = 1'b1;
		endcase
		n.txd = lvl & ~cfg.brk;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s <= TX_RST;
		end else begin
			s <= n;
		end
	end

	assign busy = s.busy;
	assign txd = s.txd;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	logic [16:0] stop_cyc;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stop_cyc <= 17'h00000;
		end else begin
			stop_cyc <= (s.st == st_stop) ? stop_cyc + 17'h00001 : 17'h00000;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	break_low_a: assert property (cfg.brk |=> !txd ##1 (!txd || !$past(cfg.brk)))
		else $error("break did not hold line low");
	no_parity_a: assert property (s.st == st_data && !cfg.pen |=> s.st != st_par)
		else $error("parity slot entered with parity disabled");
	word_len_a: assert property (s.st == st_data && n.st != st_data
			|-> s.nbit == 4'h4 + {2'h0, cfg.wlen})
		else $error("wrong number of data bits");
	stop_len_a: assert property (s.st == st_stop && n.st == st_idle
			|-> stop_cyc == stop_len - 17'h00001)
		else $error("wrong stop length");
endmodule : ulfc_tx

// ### tb/uart_line_format_control_tb.sv
// Self-checking bench for the line format block, with a frame model in integers.
// Assumes ulfc_top and the remote station model; bit time is set to 8 clocks.
`timescale 1ns/1ps
module uart_line_format_control_tb;
	import ulfc_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	ulfc_av_req_t req = '0;
	ulfc_av_rsp_t rsp;
	logic rxd;
	logic txd;
	int n_fail = 0;
	int check_count = 0;
	initial forever #25 clk = ~clk;
	ulfc_top dut_u (.clk(clk), .reset_n(reset_n), .av_req(req), .av_rsp(rsp), .rxd(rxd), .txd(txd));
	ulfc_remote rem_u (.clk(clk), .txd(txd), .rxd(rxd));
	////////////////////////////////////////////////////////////////
	task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
		int t;
		t = 0;
		@(posedge clk);
		req <= '{~w, w, a, {24'h000000, d}};
		@(posedge clk);
		while (rsp.waitrequest !== 1'b0 && t < 100) begin
			@(posedge clk);
			t++;
		end
		if (t >= 100) n_fail++;
		q = rsp.readdata[7:0];
		req.read <= 1'b0;
		req.write <= 1'b0;
	endtask : bus
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wait_idle;
		logic [7:0] q;
		int t;
		t = 0;
		q = 8'h00;
		while (q[5] !== 1'b1 && t < 300) begin
			bus(1'b0, 3'h1, 8'h00, q);
			t++;
		end
	endtask : wait_idle
	task close_out;
		$display("checks=%0d fails=%0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : close_out
	// Frame as sent on the line: start, data LSB first, parity, one stop
	function automatic logic [11:0] mk(input logic [7:0] d, input logic [5:0] f, input logic bad,
		output int nb);
		int n;
		logic [11:0] v;
		n = 5 + f[1:0];
		v = '0;
		for (int i = 0; i < n; i++) v[i + 1] = d[i];
		nb = n + 1;
		if (f[3]) begin
			v[nb] = bad ^ (f[5] ? ~f[4] : ~f[4] ^ (^v[8:1]));
			nb++;
		end
		v[nb] = 1'b1;
		nb++;
		return v;
	endfunction : mk
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (80000) @(posedge clk);
		n_fail++;
		close_out;
	end
	initial begin
		logic [7:0] q, d1, d2, m;
		logic [11:0] v, e;
		logic [5:0] f;
		logic bad;
		int nb, gap, sc, ok;
		void'($urandom(32'hA38D53B4));
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		bus(1'b0, 3'h3, 8'h00, q);
		chk(q, 8'h00);
		bus(1'b0, 3'h1, 8'h00, q);
		chk(q, 8'h30);
		bus(1'b0, 3'h2, 8'h00, q);
		chk(q, 8'h00);
		bus(1'b1, 3'h3, 8'h80, q);
		bus(1'b1, 3'h0, 8'h08, q);
		bus(1'b1, 3'h1, 8'h00, q);
		bus(1'b1, 3'h2, 8'h5A, q);
		bus(1'b0, 3'h2, 8'h00, q);
		chk(q, 8'h5A);
		bus(1'b0, 3'h0, 8'h00, q);
		chk(q, 8'h08);
		bus(1'b1, 3'h3, 8'h00, q);
		bus(1'b0, 3'h2, 8'h00, q);
		chk(q, 8'h00);
		// Break raised over a queued character
		bus(1'b1, 3'h0, 8'h55, q);
		bus(1'b1, 3'h3, 8'h43, q);
		repeat (2) @(negedge clk);
		ok = 1;
		repeat (16) begin
			@(negedge clk);
			if (txd !== 1'b0) ok = 0;
		end
		chk(ok, 1);
		bus(1'b1, 3'h3, 8'h03, q);
		wait_idle;
		chk(txd, 1'b1);
		for (int k = 0; k < 64; k++) begin
			f = k[5:0];
			wait_idle;
			bus(1'b1, 3'h3, {2'b00, f}, q);
			bus(1'b0, 3'h3, 8'h00, q);
			chk(q, {2'b00, f});
			d1 = $urandom;
			d2 = $urandom;
			e = mk(d1, f, 1'b0, nb);
			sc = f[2] ? (f[1:0] == 2'b00 ? 12 : 16) : 8;
			fork
				rem_u.grab(nb, 8, v, gap);
				begin
					bus(1'b1, 3'h0, d1, q);
					bus(1'b1, 3'h0, d2, q);
				end
			join
			chk(v & ((12'h001 << nb) - 12'h001), e);
			chk(gap >= 8 * (nb - 1) + sc && gap <= 8 * (nb - 1) + sc + 3, 1);
			bad = f[3] & 1'($urandom);
			e = mk(d1, f, bad, nb);
			rem_u.send(e, nb, 8);
			repeat (4) @(posedge clk);
			bus(1'b0, 3'h1, 8'h00, q);
			chk(q[2:0], {1'b0, bad, 1'b1});
			m = 8'hFF >> (2'h3 - f[1:0]);
			bus(1'b0, 3'h0, 8'h00, q);
			chk(q & m, d1 & m);
		end
		close_out;
	end
endmodule : uart_line_format_control_tb

// ### tb/ulfc_remote.sv
// Remote serial station: captures frames from txd and sends frames on rxd.
// Assumes a bit time of bt core clocks and a line that idles high.
`timescale 1ns/1ps
module ulfc_remote (
	input wire logic clk, // Core clock
	input wire logic txd, // Line from the block
	output logic rxd // Line into the block
);
	initial rxd = 1'b1;
	////////////////////////////////////////////////////////////////
	// Samples bits mid-way, then times the start of the next frame
	task automatic grab(input int nb, input int bt, output logic [11:0] v, output int gap);
		int t;
		v = '0;
		t = 0;
		@(negedge clk);
		while (txd !== 1'b0 && t < 4000) begin
			@(negedge clk);
			t++;
		end
		t = 0;
		while (t < 2000) begin
			if (t % bt == bt / 2 && t / bt < nb) v[t / bt] = txd;
			@(negedge clk);
			t++;
			if (t > (nb - 1) * bt + bt / 2 && txd === 1'b0) break;
		end
		gap = t;
	endtask : grab
	task automatic send(input logic [11:0] v, input int nb, input int bt);
		for (int i = 0; i < nb; i++) begin
			repeat (bt) @(posedge clk) rxd <= v[i];
		end
	endtask : send
endmodule : ulfc_remote
